// >>> amp_seq_pkg.sv
// Package of constants, states and carriers for the amplifier power sequencer.
`default_nettype none
package amp_seq_pkg;

	// ---------------------------------------------------------------
	// Clock and short waits
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 20;
	localparam int T_DV_RH_US = 100;
	localparam int T_HL_RL_US = 4;
	localparam int T_RL_DV_US = 2;
	localparam logic [23:0] DV_RH_CYC = 24'(T_DV_RH_US * CLK_MHZ);
	localparam logic [23:0] HL_RL_CYC = 24'(T_HL_RL_US * CLK_MHZ);
	localparam logic [23:0] RL_DV_CYC = 24'(T_RL_DV_US * CLK_MHZ);
	// Cycles in one millisecond; long waits scale with this.
	localparam int CYC_PER_MS_DEF = CLK_MHZ * 1000;

	// ---------------------------------------------------------------
	// Long waits in tenths of a millisecond
	// ---------------------------------------------------------------
	localparam int T_RH_I2C_DMS = 135;
	localparam int T_TRIM_DMS = 500;
	localparam int T_CLK_STABLE_DMS = 500;
	localparam int T_SD_BASE_DMS = 10;
	localparam int T_POR_BASE_DMS = 2400;
	localparam int T_PL_HL_DMS = 20;
	// Ramp factor 1.3 expressed in tenths per ramp millisecond.
	localparam int RAMP_FACTOR_DMS = 13;

	// ---------------------------------------------------------------
	// Amplifier subaddresses and values
	// ---------------------------------------------------------------
	localparam logic [7:0] SUB_SYS_CTRL2 = 8'h05;
	localparam logic [7:0] SUB_RAMP_PERIOD = 8'h1a;
	localparam logic [7:0] SUB_OSC_CAL = 8'h1b;
	localparam logic [7:0] SUB_BANK_SEL = 8'h50;
	localparam logic [7:0] SUB_FILT_LO = 8'h29;
	localparam logic [7:0] SUB_FILT_HI = 8'h36;
	localparam logic [7:0] SUB_COMP_LO = 8'h3a;
	localparam logic [7:0] SUB_COMP_HI = 8'h46;
	localparam logic [7:0] SUB_RUN_LO = 8'h06;
	localparam logic [7:0] SUB_RUN_HI = 8'h0a;
	localparam logic [7:0] VAL_TRIM = 8'h00;
	localparam logic [7:0] VAL_SD_ENTER = 8'h40;
	localparam logic [7:0] VAL_SD_EXIT = 8'h00;

	// ---------------------------------------------------------------
	// Own register map (byte offsets) and fields
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RAMP = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam int CTRL_START = 0;
	localparam int CTRL_SD_ENTER = 1;
	localparam int CTRL_SD_EXIT = 2;
	localparam int CTRL_RECONFIG = 3;
	localparam int CTRL_PWR_LOSS = 4;
	localparam int CTRL_PWR_DOWN = 5;
	localparam int CTRL_CFG_DONE = 6;
	localparam int CTRL_CLR_REFUSED = 7;
	localparam logic [7:0] RAMP_START_RST = 8'h0f;
	localparam logic [7:0] RAMP_STOP_RST = 8'h0f;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Order classes of processor configuration writes.
	localparam logic [2:0] CLS_FILT = 3'd1;
	localparam logic [2:0] CLS_COMP = 3'd2;
	localparam logic [2:0] CLS_BANK = 3'd3;
	localparam logic [2:0] CLS_OTHER = 3'd4;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		S_OFF, S_VALID, S_RSTWAIT, S_TRIM, S_TRIMWAIT, S_CONFIG,
		S_CLKWAIT, S_SDWRITE, S_SDWAIT, S_RUN, S_SHUT, S_PDN,
		S_HIZ, S_RSTLOW
	} seq_state_t;

	typedef struct packed {
		logic resetN;
		logic powerDownN;
		logic outputFloatN;
		logic digInEn;
	} amp_pins_t;

	typedef struct packed {
		logic valid;
		logic [7:0] sub;
		logic [7:0] data;
	} i2c_req_t;

endpackage
`default_nettype wire

// >>> amp_power_command_sequencer.sv
// Host-side power and command sequencer for the stereo amplifier.
//
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none
module amp_power_command_sequencer
	import amp_seq_pkg::*;
#(
	parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite slave
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Amplifier control pins
	output amp_pins_t ampPins,
	// Audio clock monitor (asynchronous level)
	input wire logic audioClkOk,
	// Register write requests to the I2C engine
	output i2c_req_t i2cReq,
	input wire logic i2cDone
);

	// ---------------------------------------------------------------
	// Parameter check
	// ---------------------------------------------------------------
	if (CYC_PER_MS < 1 || CYC_PER_MS > 25000) begin : gBadRate
		$error("CYC_PER_MS out of the range the counters serve.");
	end

	// ---------------------------------------------------------------
	// State record
	// ---------------------------------------------------------------
	typedef struct packed {
		seq_state_t phase;
		logic [23:0] waitCnt;
		logic [23:0] clkCnt;
		logic [23:0] porCnt;
		logic porRun;
		logic porDone;
		logic trimSeen;
		logic [2:0] stage;
		logic sdEnter;
		logic cfgAfterClk;
		logic pdAfterSd;
		logic cmdPend;
		logic [7:0] cmdSub;
		logic [7:0] cmdData;
		logic refused;
		logic [7:0] rampStart;
		logic [7:0] rampStop;
		amp_pins_t pins;
		i2c_req_t req;
		logic clkSync1;
		logic clkSync2;
		logic awGot;
		logic wGot;
		logic [7:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Tenths of a millisecond to cycles, rounded up.
	function automatic logic [23:0] dmsCycles(input int unsigned dms);
		longint unsigned prod;
		prod = longint'(dms) * longint'(CYC_PER_MS) + 64'd9;
		return 24'(prod / 64'd10);
	endfunction

	// Base wait plus 1.3 times a ramp period in milliseconds.
	function automatic logic [23:0] rampWait(input int unsigned baseDms,
			input logic [7:0] rampMs);
		return dmsCycles(baseDms + RAMP_FACTOR_DMS * int'(rampMs));
	endfunction

	// Order class of a configuration subaddress.
	function automatic logic [2:0] subClass(input logic [7:0] sub);
		if (sub >= SUB_FILT_LO && sub <= SUB_FILT_HI)
			return CLS_FILT;
		else if (sub >= SUB_COMP_LO && sub <= SUB_COMP_HI)
			return CLS_COMP;
		else if (sub == SUB_BANK_SEL)
			return CLS_BANK;
		else
			return CLS_OTHER;
	endfunction

	logic clkStable;
	logic [23:0] clkStableCyc;
	assign clkStableCyc = dmsCycles(T_CLK_STABLE_DMS);
	assign clkStable = s_r.clkCnt >= clkStableCyc;

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		logic doWrite;
		logic badAddr;
		logic [7:0] ctrl;
		logic waitDone;
		logic cmdOk;
		s_nxt = s_r;
		doWrite = 1'b0;
		badAddr = 1'b0;
		ctrl = 8'h00;
		waitDone = (s_r.waitCnt == 24'd0);
		cmdOk = 1'b0;

		// Clock monitor: two flops, then a stability counter.
		s_nxt.clkSync1 = audioClkOk;
		s_nxt.clkSync2 = s_r.clkSync1;
		if (!s_r.clkSync2)
			s_nxt.clkCnt = 24'd0;
		else if (!clkStable)
			s_nxt.clkCnt = s_r.clkCnt + 24'd1;

		// Write address and data are taken in either order.
		if (s_r.awready && s_axi_awvalid) begin
			s_nxt.awready = 1'b0;
			s_nxt.awGot = 1'b1;
			s_nxt.awAddr = s_axi_awaddr[7:0];
		end
		if (s_r.wready && s_axi_wvalid) begin
			s_nxt.wready = 1'b0;
			s_nxt.wGot = 1'b1;
			s_nxt.wData = s_axi_wdata;
			s_nxt.wStrb = s_axi_wstrb;
		end
		if (s_r.awGot && s_r.wGot && !s_r.bvalid) begin
			doWrite = 1'b1;
			badAddr = s_r.awAddr[1:0] != 2'b00 || s_r.awAddr > OFS_STATUS;
			s_nxt.awGot = 1'b0;
			s_nxt.wGot = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = badAddr ? RESP_SLVERR : RESP_OKAY;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
			s_nxt.awready = 1'b1;
			s_nxt.wready = 1'b1;
		end

		// Register write effects.
		if (doWrite && !badAddr) begin
			unique case (s_r.awAddr)
				OFS_CTRL: begin
					if (s_r.wStrb[0])
						ctrl = s_r.wData[7:0];
				end
				OFS_RAMP: begin
					if (s_r.wStrb[0])
						s_nxt.rampStart = s_r.wData[7:0];
					if (s_r.wStrb[1])
						s_nxt.rampStop = s_r.wData[15:8];
				end
				OFS_CMD: begin
					if (s_r.wStrb[1:0] == 2'b11) begin
						if (s_r.cmdPend) begin
							s_nxt.refused = 1'b1;
						end else begin
							s_nxt.cmdPend = 1'b1;
							s_nxt.cmdSub = s_r.wData[15:8];
							s_nxt.cmdData = s_r.wData[7:0];
						end
					end
				end
				default: begin
				end
			endcase
		end
		if (ctrl[CTRL_CLR_REFUSED] && !(doWrite && s_r.awAddr == OFS_CMD))
			s_nxt.refused = 1'b0;

		// Register reads answer one at a time.
		if (s_r.arready && s_axi_arvalid) begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			unique case (s_axi_araddr[7:0])
				OFS_CTRL: s_nxt.rdata = 32'h0;
				OFS_RAMP: s_nxt.rdata = {16'h0, s_r.rampStop, s_r.rampStart};
				OFS_CMD: s_nxt.rdata = {15'h0, s_r.cmdPend, s_r.cmdSub,
						s_r.cmdData};
				OFS_STATUS: s_nxt.rdata = {24'h0, s_r.refused, s_r.porDone,
						clkStable, s_r.req.valid, 4'(s_r.phase)};
				default: begin
					s_nxt.rdata = 32'h0;
					s_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
			s_nxt.arready = 1'b1;
		end

		// Power-on wait after the first trim; only reset clears it.
		if (s_r.porRun) begin
			if (s_r.porCnt == 24'd0) begin
				s_nxt.porRun = 1'b0;
				s_nxt.porDone = 1'b1;
			end else begin
				s_nxt.porCnt = s_r.porCnt - 24'd1;
			end
		end

		// A finished I2C write drops the request.
		if (s_r.req.valid && i2cDone)
			s_nxt.req.valid = 1'b0;

		if (!waitDone)
			s_nxt.waitCnt = s_r.waitCnt - 24'd1;

		// Main sequence.
		unique case (s_r.phase)
			S_OFF: begin
				s_nxt.pins = '0;
				if (ctrl[CTRL_START]) begin
					s_nxt.pins.powerDownN = 1'b1;
					s_nxt.pins.outputFloatN = 1'b1;
					s_nxt.pins.digInEn = 1'b1;
					s_nxt.waitCnt = DV_RH_CYC;
					s_nxt.phase = S_VALID;
				end
			end
			S_VALID: begin
				if (waitDone) begin
					s_nxt.pins.resetN = 1'b1;
					s_nxt.waitCnt = dmsCycles(T_RH_I2C_DMS);
					s_nxt.phase = S_RSTWAIT;
				end
			end
			S_RSTWAIT: begin
				if (waitDone) begin
					s_nxt.req = '{1'b1, SUB_OSC_CAL, VAL_TRIM};
					s_nxt.phase = S_TRIM;
				end
			end
			S_TRIM: begin
				if (i2cDone) begin
					if (!s_r.trimSeen) begin
						s_nxt.porRun = 1'b1;
						s_nxt.porCnt = rampWait(T_POR_BASE_DMS, s_r.rampStart);
					end
					s_nxt.trimSeen = 1'b1;
					// One wait covers the trim and the rate detection.
					s_nxt.waitCnt = dmsCycles(T_TRIM_DMS);
					s_nxt.phase = S_TRIMWAIT;
				end
			end
			S_TRIMWAIT: begin
				if (waitDone) begin
					s_nxt.stage = CLS_FILT;
					s_nxt.phase = S_CONFIG;
				end
			end
			S_CONFIG: begin
				if (s_r.cmdPend && !s_r.req.valid) begin
					// Classes may repeat but never step backwards.
					cmdOk = subClass(s_r.cmdSub) >= s_r.stage
						&& s_r.cmdSub != SUB_OSC_CAL
						&& s_r.cmdSub != SUB_SYS_CTRL2;
					if (cmdOk)
						s_nxt.stage = subClass(s_r.cmdSub);
				end
				if (ctrl[CTRL_CFG_DONE] && !s_r.cmdPend && !s_r.req.valid) begin
					s_nxt.sdEnter = 1'b0;
					s_nxt.cfgAfterClk = 1'b0;
					s_nxt.phase = S_CLKWAIT;
				end
			end
			S_CLKWAIT: begin
				// Shutdown moves wait for the power-on window to close.
				if (clkStable && (s_r.cfgAfterClk || s_r.porDone)) begin
					if (s_r.cfgAfterClk) begin
						s_nxt.stage = CLS_FILT;
						s_nxt.phase = S_CONFIG;
					end else begin
						s_nxt.req = '{1'b1, SUB_SYS_CTRL2,
							s_r.sdEnter ? VAL_SD_ENTER : VAL_SD_EXIT};
						s_nxt.phase = S_SDWRITE;
					end
				end
			end
			S_SDWRITE: begin
				if (i2cDone) begin
					s_nxt.waitCnt = s_r.sdEnter ?
						rampWait(T_SD_BASE_DMS, s_r.rampStop) :
						rampWait(T_SD_BASE_DMS, s_r.rampStart);
					s_nxt.phase = S_SDWAIT;
				end
			end
			S_SDWAIT: begin
				if (waitDone) begin
					if (!s_r.sdEnter) begin
						s_nxt.phase = S_RUN;
					end else if (s_r.pdAfterSd) begin
						s_nxt.pins.resetN = 1'b0;
						s_nxt.waitCnt = RL_DV_CYC;
						s_nxt.phase = S_RSTLOW;
					end else begin
						s_nxt.phase = S_SHUT;
					end
				end
			end
			S_RUN: begin
				if (s_r.cmdPend && !s_r.req.valid)
					cmdOk = s_r.cmdSub >= SUB_RUN_LO
						&& s_r.cmdSub <= SUB_RUN_HI;
				if (ctrl[CTRL_SD_ENTER] || ctrl[CTRL_PWR_DOWN]) begin
					s_nxt.sdEnter = 1'b1;
					s_nxt.cfgAfterClk = 1'b0;
					s_nxt.pdAfterSd = ctrl[CTRL_PWR_DOWN];
					s_nxt.phase = S_CLKWAIT;
				end
			end
			S_SHUT: begin
				// Audio clocks are not watched while idle here.
				if (ctrl[CTRL_PWR_DOWN]) begin
					s_nxt.pins.resetN = 1'b0;
					s_nxt.waitCnt = RL_DV_CYC;
					s_nxt.phase = S_RSTLOW;
				end else if (ctrl[CTRL_SD_EXIT] || ctrl[CTRL_RECONFIG]) begin
					s_nxt.sdEnter = 1'b0;
					s_nxt.cfgAfterClk = ctrl[CTRL_RECONFIG];
					s_nxt.phase = S_CLKWAIT;
				end
			end
			S_PDN: begin
				if (waitDone) begin
					s_nxt.pins.outputFloatN = 1'b0;
					s_nxt.waitCnt = HL_RL_CYC;
					s_nxt.phase = S_HIZ;
				end
			end
			S_HIZ: begin
				if (waitDone) begin
					s_nxt.pins.resetN = 1'b0;
					s_nxt.waitCnt = RL_DV_CYC;
					s_nxt.phase = S_RSTLOW;
				end
			end
			S_RSTLOW: begin
				if (waitDone) begin
					s_nxt.pins = '0;
					s_nxt.pdAfterSd = 1'b0;
					s_nxt.phase = S_OFF;
				end
			end
		endcase

		// Forward or refuse a pending software write.
		if (s_r.cmdPend && !s_r.req.valid) begin
			if (cmdOk) begin
				s_nxt.req = '{1'b1, s_r.cmdSub, s_r.cmdData};
			end else if (s_r.phase != S_CONFIG || s_r.cmdPend) begin
				s_nxt.refused = 1'b1;
			end
			s_nxt.cmdPend = 1'b0;
		end

		// Power loss overrides every phase but S_PDN and S_HIZ once resetN is released.
		if (ctrl[CTRL_PWR_LOSS] && s_r.pins.resetN
				&& s_r.phase != S_PDN && s_r.phase != S_HIZ) begin
			s_nxt.pins.powerDownN = 1'b0;
			s_nxt.req.valid = 1'b0;
			s_nxt.waitCnt = dmsCycles(T_PL_HL_DMS);
			s_nxt.phase = S_PDN;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.phase <= S_OFF;
			s_r.rampStart <= RAMP_START_RST;
			s_r.rampStop <= RAMP_STOP_RST;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state record.
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = s_r.rdata;
	assign ampPins = s_r.pins;
	assign i2cReq = s_r.req;

endmodule
`default_nettype wire

// >>> amp_model.sv
// Behavioural model of the amplifier register file behind the I2C engine.
`default_nettype none
module amp_model
	import amp_seq_pkg::*;
#(
	parameter int SLOW_CYC = 9
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register writes and their answer
	input wire i2c_req_t i2cReq,
	input wire logic slow,
	output logic i2cDone
);
	logic [7:0] mem [256];
	logic [4:0] cnt;

	// Writes finish two or SLOW_CYC+1 cycles after the request. No audio clock enters
	// here, so stopped clocks in shutdown never block the model.
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 256; i++)
				mem[i] <= 8'h00;
			mem[SUB_SYS_CTRL2] <= 8'h40;
			mem[SUB_RAMP_PERIOD] <= 8'h0f;
			mem[SUB_OSC_CAL] <= 8'h82;
			cnt <= '0;
			i2cDone <= 1'b0;
		end else begin
			i2cDone <= 1'b0;
			if (!i2cReq.valid)
				cnt <= '0;
			else if (!i2cDone) begin
				cnt <= cnt + 5'h1;
				if (cnt >= (slow ? 5'(SLOW_CYC) : 5'h1)) begin
					i2cDone <= 1'b1;
					mem[i2cReq.sub] <= i2cReq.data;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> amp_seq_properties.sv
// Timing checker of the amplifier pins and I2C requests.
`default_nettype none
module amp_seq_properties
	import amp_seq_pkg::*;
#(
	parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
	// Clock, reset and write bus
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	// Amplifier side
	input wire amp_pins_t ampPins,
	input wire logic audioClkOk,
	input wire i2c_req_t i2cReq,
	input wire logic i2cDone
);
	localparam int RH_CYC = T_RH_I2C_DMS * CYC_PER_MS / 10;
	localparam int TRIM_CYC = T_TRIM_DMS * CYC_PER_MS / 10;
	localparam int CLK_CYC = T_CLK_STABLE_DMS * CYC_PER_MS / 10;
	localparam int PL_CYC = T_PL_HL_DMS * CYC_PER_MS / 10;
	logic [23:0] dvCnt, rhCnt, plCnt, hlCnt, rlCnt, clkCnt, gapCnt, porCnt;
	logic [15:0] ramp;
	logic [7:0] lastSub, lastData;
	logic trimSeen;
	int sdNeed, porNeed;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Level durations; the power-on count starts at the first trim and is
	// cleared only by reset, so later trims cannot restart it.
	always_ff @(posedge clk) begin
		if (rst) begin
			{dvCnt, rhCnt, plCnt, hlCnt, rlCnt, clkCnt, gapCnt} <= '0;
			{porCnt, lastSub, lastData, trimSeen} <= '0;
			ramp <= {RAMP_STOP_RST, RAMP_START_RST};
		end else begin
			dvCnt <= ampPins.digInEn ? dvCnt + 24'h1 : '0;
			rhCnt <= ampPins.resetN ? rhCnt + 24'h1 : '0;
			plCnt <= ampPins.powerDownN ? '0 : plCnt + 24'h1;
			hlCnt <= ampPins.outputFloatN ? '0 : hlCnt + 24'h1;
			rlCnt <= ampPins.resetN ? '0 : rlCnt + 24'h1;
			clkCnt <= audioClkOk ? clkCnt + 24'h1 : '0;
			gapCnt <= i2cDone ? '0 : gapCnt + 24'h1;
			if (i2cDone) begin
				lastSub <= i2cReq.sub;
				lastData <= i2cReq.data;
			end
			if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
				s_axi_wready && s_axi_awaddr[7:0] == OFS_RAMP)
				ramp <= s_axi_wdata[15:0];
			if (i2cReq.valid && i2cReq.sub == SUB_OSC_CAL)
				trimSeen <= 1'b1;
			if (trimSeen)
				porCnt <= porCnt + 24'h1;
		end
	end

	// Ramp dependent waits in cycles.
	always_comb begin
		sdNeed = (T_SD_BASE_DMS + RAMP_FACTOR_DMS * int'(lastData ==
			VAL_SD_ENTER ? ramp[15:8] : ramp[7:0])) * CYC_PER_MS / 10;
		porNeed = (T_POR_BASE_DMS + RAMP_FACTOR_DMS * int'(ramp[7:0])) *
			CYC_PER_MS / 10;
	end

	property p_idle_low;
		!ampPins.digInEn |-> ampPins == '0 && !i2cReq.valid;
	endproperty
	a_idle_low: assert property (p_idle_low)
		else $error("Pin or request active with inputs off.");
	property p_release;
		$rose(ampPins.resetN) |-> ampPins.powerDownN &&
			ampPins.outputFloatN && dvCnt >= DV_RH_CYC;
	endproperty
	a_release: assert property (p_release)
		else $error("Reset released too early.");
	property p_rh_i2c;
		$rose(i2cReq.valid) |-> ampPins.resetN && rhCnt >= RH_CYC;
	endproperty
	a_rh_i2c: assert property (p_rh_i2c)
		else $error("Request too soon after reset release.");
	property p_trim_gap;
		$rose(i2cReq.valid) && lastSub == SUB_OSC_CAL |->
			gapCnt >= TRIM_CYC - 1;
	endproperty
	a_trim_gap: assert property (p_trim_gap)
		else $error("Request too soon after trim.");
	property p_sd_gap;
		$rose(i2cReq.valid) && lastSub == SUB_SYS_CTRL2 |->
			gapCnt >= sdNeed - 1;
	endproperty
	a_sd_gap: assert property (p_sd_gap)
		else $error("Request too soon after shutdown change.");
	property p_por;
		$rose(i2cReq.valid) && i2cReq.sub == SUB_SYS_CTRL2 |->
			trimSeen && porCnt >= porNeed && clkCnt >= CLK_CYC;
	endproperty
	a_por: assert property (p_por)
		else $error("Shutdown change before window or clocks.");
	property p_pdn_first;
		$fell(ampPins.outputFloatN) && ampPins.resetN |->
			!ampPins.powerDownN && plCnt >= PL_CYC;
	endproperty
	a_pdn_first: assert property (p_pdn_first)
		else $error("Float pin dropped too early.");
	property p_float_rst;
		$fell(ampPins.resetN) && !ampPins.outputFloatN |->
			hlCnt >= HL_RL_CYC;
	endproperty
	a_float_rst: assert property (p_float_rst)
		else $error("Reset dropped too soon after float.");
	property p_hold_in;
		$fell(ampPins.digInEn) |-> !ampPins.resetN && rlCnt >= RL_DV_CYC;
	endproperty
	a_hold_in: assert property (p_hold_in)
		else $error("Inputs dropped too soon after reset.");
	property p_ctl_down;
		$fell(ampPins.resetN) && ampPins.outputFloatN |->
			lastSub == SUB_SYS_CTRL2 && lastData == VAL_SD_ENTER;
	endproperty
	a_ctl_down: assert property (p_ctl_down)
		else $error("Reset asserted without shutdown entry.");
	c_release: cover property ($rose(ampPins.resetN));
	c_loss: cover property ($fell(ampPins.outputFloatN));
	c_enter: cover property ($rose(i2cReq.valid) &&
		i2cReq.data == VAL_SD_ENTER && i2cReq.sub == SUB_SYS_CTRL2);
endmodule
bind amp_power_command_sequencer amp_seq_properties #(
	.CYC_PER_MS(CYC_PER_MS)
) props (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .ampPins(ampPins),
	.audioClkOk(audioClkOk), .i2cReq(i2cReq), .i2cDone(i2cDone));
`default_nettype wire

// >>> tb_amp_power_command_sequencer.sv
// Self-checking bench of the amplifier power and command sequencer.
`default_nettype none
module tb_amp_power_command_sequencer
	import amp_seq_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] awaddr, wdata, araddr, rdata, d;
	logic awvalid, awready, wvalid, wready, bvalid, bready, slow;
	logic arvalid, arready, rvalid, rready, audioClkOk, i2cDone;
	logic [1:0] bresp, rresp, r;
	amp_pins_t ampPins;
	i2c_req_t i2cReq;
	int nFail, nChecks, seed;

	// Clock of 50 ns period.
	always #25 clk = ~clk;

	amp_power_command_sequencer #(.CYC_PER_MS(20)) dut (.clk(clk),
		.rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ampPins(ampPins),
		.audioClkOk(audioClkOk), .i2cReq(i2cReq), .i2cDone(i2cDone));
	amp_model amp (.clk(clk), .rst(rst), .i2cReq(i2cReq), .slow(slow),
		.i2cDone(i2cDone));

	function automatic logic [7:0] expMem(input logic bad,
		input logic [7:0] old, input logic [7:0] dat);
		return bad ? old : dat;
	endfunction

	task automatic endSim();
		$display("Checks %0d, mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			nFail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Write: address and data offered together, each dropped once taken.
	// Only the watchdog ends a wait for the slave's answer.
	task automatic axw(input logic [7:0] a, input logic [31:0] dat);
		logic got;
		got = 1'b0;
		@(posedge clk);
		awaddr <= {24'h0, a};
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got) begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				got = 1'b1;
				r = bresp;
				bready <= 1'b0;
			end
		end
	endtask

	task automatic axr(input logic [7:0] a);
		logic got;
		got = 1'b0;
		@(posedge clk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got) begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				got = 1'b1;
				{d, r} = {rdata, rresp};
				rready <= 1'b0;
			end
		end
	endtask

	task automatic ctrl(input int b);
		axw(OFS_CTRL, 32'h1 << b);
	endtask

	task automatic waitPhase(input logic [3:0] p);
		d = {28'h0, ~p};
		for (int n = 0; n < 6000 && d[3:0] !== p; n++)
			axr(OFS_STATUS);
		chk(d[3:0], p);
	endtask

	// Forwarded writes land in the model; refused ones set the flag.
	task automatic cmd(input logic [7:0] sub, input logic bad);
		logic [7:0] old, dat;
		old = amp.mem[sub];
		dat = 8'($random(seed));
		slow <= 1'($random(seed));
		axw(OFS_CMD, {16'h0, sub, dat});
		d = 32'h1_0000;
		for (int n = 0; n < 500 && d[16]; n++)
			axr(OFS_CMD);
		// A slow engine may still be busy; wait until the write has landed.
		d = 32'h10;
		for (int n = 0; n < 500 && d[4]; n++)
			axr(OFS_STATUS);
		chk(d[7], bad);
		chk(amp.mem[sub], expMem(bad, old, dat));
		if (bad)
			ctrl(CTRL_CLR_REFUSED);
	endtask

	task automatic cfg();
		cmd(SUB_FILT_LO, 1'b0);
		cmd(SUB_COMP_LO, 1'b0);
		cmd(SUB_BANK_SEL, 1'b0);
		cmd(SUB_FILT_HI, 1'b1);
		cmd(SUB_OSC_CAL, 1'b1);
		cmd(8'h08, 1'b0);
		ctrl(CTRL_CFG_DONE);
		waitPhase(S_RUN);
		chk(amp.mem[SUB_SYS_CTRL2], VAL_SD_EXIT);
	endtask

	// Main sequence: power-up, run, shutdown, loss and controlled down.
	initial begin
		seed = 32'h4c4d;
		{awaddr, wdata, araddr} = '0;
		{awvalid, wvalid, bready, arvalid, rready, audioClkOk, slow} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		axr(OFS_RAMP);
		chk(d, {16'h0, RAMP_STOP_RST, RAMP_START_RST});
		axr(8'h10);
		chk(r, RESP_SLVERR);
		chk(ampPins, 4'h0);
		d[7:0] = 8'(($random(seed) & 3) + 1);
		axw(OFS_RAMP, {16'h0, d[7:0] + 8'h1, d[7:0]});
		chk(r, RESP_OKAY);
		audioClkOk <= 1'b1;
		ctrl(CTRL_START);
		waitPhase(S_CONFIG);
		chk(amp.mem[SUB_OSC_CAL], VAL_TRIM);
		cfg();
		cmd(8'h07, 1'b0);
		cmd(SUB_FILT_LO, 1'b1);
		ctrl(CTRL_SD_ENTER);
		waitPhase(S_SHUT);
		chk(amp.mem[SUB_SYS_CTRL2], VAL_SD_ENTER);
		audioClkOk <= 1'b0;
		cmd(8'h06, 1'b1);
		audioClkOk <= 1'b1;
		ctrl(CTRL_RECONFIG);
		waitPhase(S_CONFIG);
		axr(OFS_STATUS);
		chk(d[5], 1'b1);
		cfg();
		ctrl(CTRL_PWR_LOSS);
		waitPhase(S_OFF);
		chk(ampPins, 4'h0);
		ctrl(CTRL_START);
		waitPhase(S_CONFIG);
		cfg();
		ctrl(CTRL_PWR_DOWN);
		waitPhase(S_OFF);
		chk(amp.mem[SUB_SYS_CTRL2], VAL_SD_ENTER);
		ctrl(CTRL_START);
		repeat (300) @(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		axr(OFS_STATUS);
		chk(d[3:0], S_OFF);
		endSim();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		repeat (90000) @(posedge clk);
		nFail++;
		endSim();
	end
endmodule
`default_nettype wire
